// ### hw/sdlc_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sdlc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Flush, used when the shift register is cleared
    input  wire logic             flush
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("sdlc_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      wr_ptr_next;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      rd_ptr_next;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (flush) begin
            rd_ptr_next = wr_ptr_reg;
        end else begin
            if (push) begin
                wr_ptr_next = wr_ptr_reg + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr_next = rd_ptr_reg + (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_reg[i] <= '0;
                end else if (push && wr_ptr_reg[AW-1:0] == AW'(i)) begin
                    mem_reg[i] <= in_data;
                end
            end
        end
    endgenerate
endmodule // sdlc_fifo

// ### hw/sdlc_line_ctrl.sv
// Line control of a TFT source driver with its timing generator bypassed.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sdlc_params.svh"

package sdlc_pkg;
    typedef enum logic [1:0] {
        SDLC_OUT_STARTUP = 2'b00,
        SDLC_OUT_HIZ     = 2'b01,
        SDLC_OUT_SETUP   = 2'b10,
        SDLC_OUT_DRIVE   = 2'b11
    } sdlc_out_state_type;
endpackage

module sdlc_line_ctrl
    import sdlc_pkg::*;
#(
    parameter int PIXELS     = 80,
    parameter int DATA_W     = 18,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Register port
    input  wire logic [`SDLC_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [15:0]                  reg_rdata,
    // Mode select
    input  wire logic                    timing_gen_bypass_select,
    // Cascade start pulses, two-way
    input  wire logic                    right_start_pulse_in,
    output logic                         right_start_pulse_out,
    output logic                         right_start_pulse_oe,
    input  wire logic                    left_start_pulse_in,
    output logic                         left_start_pulse_out,
    output logic                         left_start_pulse_oe,
    // Line strobes
    input  wire logic                    line_latch_strobe,
    input  wire logic                    amp_output_enable_strobe,
    input  wire logic                    polarity_select,
    input  wire logic                    polarity_sample_strobe,
    // Pixel data stream
    input  wire logic                    pix_valid,
    output logic                         pix_ready,
    input  wire logic [DATA_W-1:0]       pix_data,
    // Converter side
    output logic [DATA_W*PIXELS-1:0]     dac_data,
    output logic                         dac_load,
    output logic                         positive_polarity,
    output logic                         common_high,
    output logic                         amp_enable,
    output logic                         output_switch_on,
    output logic                         bias_setup,
    // Supply configuration
    output logic                         boost_triple_select,
    output logic                         external_divider_select,
    output logic [2:0]                   source_level_select,
    output logic [2:0]                   gate_ref_level_select
);
    localparam int CW = $clog2(PIXELS + 1);

    initial begin
        if (PIXELS < 2 || DATA_W < 1 || FIFO_DEPTH < 2) begin
            $error("sdlc_line_ctrl: parameters out of range");
        end
    end

    // ======================================================================
    // Input sampling and edge detection
    logic [6:0] in_now;
    logic [6:0] samp_reg;
    logic [6:0] prev_reg;
    logic       bypass;
    logic       left_shift;
    logic       start_hi;
    logic       stb_hi;
    logic       stb_rise;
    logic       ap_rise;
    logic       ap_fall;
    logic       polarity_sample_strobe_rise;

    assign in_now = {polarity_select, timing_gen_bypass_select, polarity_sample_strobe, amp_output_enable_strobe,
                     line_latch_strobe, left_start_pulse_in, right_start_pulse_in};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            samp_reg <= 7'h00;
            prev_reg <= 7'h00;
        end else begin
            samp_reg <= in_now;
            prev_reg <= samp_reg;
        end
    end

    assign bypass     = samp_reg[5];
    assign stb_hi     = samp_reg[2] && bypass;
    assign stb_rise   = samp_reg[2] && !prev_reg[2] && bypass;
    assign ap_rise    = samp_reg[3] && !prev_reg[3] && bypass;
    assign ap_fall    = !samp_reg[3] && prev_reg[3] && bypass;
    assign polarity_sample_strobe_rise  = samp_reg[4] && !prev_reg[4] && bypass;

    // ======================================================================
    // Configuration register
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;

    assign left_shift = cfg_reg[`SDLC_CFG_LEFT_BIT];
    assign start_hi   = bypass && (left_shift ? samp_reg[1] : samp_reg[0]);

    always_comb begin
        cfg_next = cfg_reg;
        if (reg_wr && reg_addr == `SDLC_REG_CONFIG) begin
            cfg_next = reg_wdata & 16'h01FF;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= `SDLC_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign boost_triple_select     = cfg_reg[`SDLC_CFG_BOOST_BIT];
    assign external_divider_select = cfg_reg[`SDLC_CFG_EXTDIV_BIT];
    assign source_level_select     = cfg_reg[`SDLC_CFG_SRCLVL_MSB:`SDLC_CFG_SRCLVL_LSB];
    assign gate_ref_level_select   = cfg_reg[`SDLC_CFG_GATELVL_MSB:`SDLC_CFG_GATELVL_LSB];

    // ======================================================================
    // Data fetch into the shift register through the FIFO
    logic              fifo_valid;
    logic              fifo_ready;
    logic [DATA_W-1:0] fifo_data;

    // Clearing on the strobe also drops buffered words of the old line.
    sdlc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (pix_valid),
        .in_ready  (pix_ready),
        .in_data   (pix_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data),
        .flush     (stb_rise)
    );

    logic [DATA_W*PIXELS-1:0] shift_reg;
    logic [DATA_W*PIXELS-1:0] shift_next;
    logic [CW-1:0]            count_reg;
    logic [CW-1:0]            count_next;
    logic                     fetch_reg;
    logic                     fetch_next;
    logic                     ovf_reg;
    logic                     ovf_next;
    logic [1:0]               carry_reg;
    logic [1:0]               carry_next;
    logic                     take;

    // The drain side stalls while no fetch is in progress.
    assign fifo_ready = fetch_reg && !stb_rise;
    assign take       = fifo_valid && fifo_ready;

    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        fetch_next = fetch_reg;
        ovf_next   = ovf_reg;
        carry_next = (carry_reg != 2'h0) ? carry_reg - 2'h1 : 2'h0;
        if (stb_rise) begin
            shift_next = '0;
            count_next = '0;
            fetch_next = 1'b0;
        end else begin
            if (start_hi && !fetch_reg) begin
                fetch_next = 1'b1;
                count_next = '0;
            end
            if (take) begin
                if (left_shift) begin
                    shift_next = {fifo_data, shift_reg[DATA_W*PIXELS-1:DATA_W]};
                end else begin
                    shift_next = {shift_reg[DATA_W*(PIXELS-1)-1:0], fifo_data};
                end
                count_next = count_reg + CW'(1);
                if (count_reg == CW'(PIXELS - 1)) begin
                    fetch_next = 1'b0;
                    carry_next = 2'(`SDLC_CARRY_CYCLES);
                end
            end
        end
        if (pix_valid && !pix_ready) begin
            ovf_next = 1'b1;
        end else if (reg_rd && reg_addr == `SDLC_REG_STATUS) begin
            ovf_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
            count_reg <= '0;
            fetch_reg <= 1'b0;
            ovf_reg   <= 1'b0;
            carry_reg <= 2'h0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            fetch_reg <= fetch_next;
            ovf_reg   <= ovf_next;
            carry_reg <= carry_next;
        end
    end

    // Start pulse pins: only the output side of the cascade is driven.
    always_comb begin
        right_start_pulse_oe  = bypass && left_shift;
        left_start_pulse_oe   = bypass && !left_shift;
        right_start_pulse_out = right_start_pulse_oe && (carry_reg != 2'h0);
        left_start_pulse_out  = left_start_pulse_oe && (carry_reg != 2'h0);
    end

    // ======================================================================
    // Latch, polarity and output stage
    sdlc_out_state_type state_reg;
    sdlc_out_state_type state_next;
    logic [DATA_W*PIXELS-1:0] dac_next;
    logic                     load_next;
    logic                     pol_reg;
    logic                     pol_next;
    logic                     normal_reg;
    logic                     normal_next;
    logic [CW-1:0]            lines_reg;
    logic [CW-1:0]            lines_next;

    always_comb begin
        state_next  = state_reg;
        dac_next    = dac_data;
        load_next   = 1'b0;
        pol_next    = pol_reg;
        normal_next = normal_reg;
        lines_next  = lines_reg;
        if (stb_hi && !prev_reg[2]) begin
            dac_next   = shift_reg;
            load_next  = 1'b1;
            lines_next = lines_reg + CW'(1);
        end
        if (stb_rise) begin
            normal_next = 1'b1;
        end
        if (polarity_sample_strobe_rise) begin
            pol_next = samp_reg[6];
        end
        unique case (state_reg)
            SDLC_OUT_STARTUP: begin
                if (stb_rise) begin
                    state_next = SDLC_OUT_HIZ;
                end
            end
            SDLC_OUT_HIZ: begin
                if (ap_rise) begin
                    state_next = SDLC_OUT_SETUP;
                end
            end
            SDLC_OUT_SETUP: begin
                if (stb_rise) begin
                    state_next = SDLC_OUT_HIZ;
                end else if (ap_fall) begin
                    state_next = SDLC_OUT_DRIVE;
                end
            end
            SDLC_OUT_DRIVE: begin
                if (stb_rise) begin
                    state_next = SDLC_OUT_HIZ;
                end else if (ap_rise) begin
                    state_next = SDLC_OUT_SETUP;
                end
            end
        endcase
        if (!bypass) begin
            state_next = SDLC_OUT_STARTUP;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= SDLC_OUT_STARTUP;
            dac_data   <= '0;
            dac_load   <= 1'b0;
            pol_reg    <= 1'b0;
            normal_reg <= 1'b0;
            lines_reg  <= '0;
        end else begin
            state_reg  <= state_next;
            dac_data   <= dac_next;
            dac_load   <= load_next;
            pol_reg    <= pol_next;
            normal_reg <= normal_next;
            lines_reg  <= lines_next;
        end
    end

    assign positive_polarity = pol_reg;
    assign common_high       = !pol_reg;
    assign bias_setup        = (state_reg == SDLC_OUT_SETUP);
    assign amp_enable        = (state_reg == SDLC_OUT_DRIVE);
    assign output_switch_on  = (state_reg == SDLC_OUT_DRIVE);

    // ======================================================================
    // Register read port, data one cycle after the strobe
    logic [15:0] rdata_next;

    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `SDLC_REG_CONFIG: begin
                    rdata_next = cfg_reg;
                end
                `SDLC_REG_STATUS: begin
                    rdata_next[`SDLC_ST_NORMAL_BIT] = normal_reg;
                    rdata_next[`SDLC_ST_FETCH_BIT]  = fetch_reg;
                    rdata_next[`SDLC_ST_HIZ_BIT]    = !output_switch_on;
                    rdata_next[`SDLC_ST_DRIVE_BIT]  = amp_enable;
                    rdata_next[`SDLC_ST_POL_BIT]    = pol_reg;
                    rdata_next[`SDLC_ST_COMHI_BIT]  = !pol_reg;
                    rdata_next[`SDLC_ST_BYPASS_BIT] = bypass;
                    rdata_next[`SDLC_ST_OVF_BIT]    = ovf_reg;
                end
                `SDLC_REG_LINE_CNT: begin
                    rdata_next = 16'(lines_reg);
                end
                `SDLC_REG_PIXEL_CNT: begin
                    rdata_next = 16'(count_reg);
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end
endmodule // sdlc_line_ctrl

// ### hw/sdlc_params.svh
// Constants for the source driver line control block.
`ifndef SDLC_PARAMS_SVH
`define SDLC_PARAMS_SVH

// ==========================================================================
// Register map
`define SDLC_ADDR_W          4
`define SDLC_REG_CONFIG      4'h0
`define SDLC_REG_STATUS      4'h1
`define SDLC_REG_LINE_CNT    4'h2
`define SDLC_REG_PIXEL_CNT   4'h3

// ==========================================================================
// Config register fields
`define SDLC_CFG_BOOST_BIT   0
`define SDLC_CFG_EXTDIV_BIT  1
`define SDLC_CFG_SRCLVL_LSB  2
`define SDLC_CFG_SRCLVL_MSB  4
`define SDLC_CFG_GATELVL_LSB 5
`define SDLC_CFG_GATELVL_MSB 7
`define SDLC_CFG_LEFT_BIT    8
`define SDLC_CFG_RESET       16'h0000

// ==========================================================================
// Status register fields
`define SDLC_ST_NORMAL_BIT   0
`define SDLC_ST_FETCH_BIT    1
`define SDLC_ST_HIZ_BIT      2
`define SDLC_ST_DRIVE_BIT    3
`define SDLC_ST_POL_BIT      4
`define SDLC_ST_COMHI_BIT    5
`define SDLC_ST_BYPASS_BIT   6
`define SDLC_ST_OVF_BIT      7

// ==========================================================================
// Timing: start pulse passed on to the cascade, in ns.
`define SDLC_CLK_PERIOD_NS   8
`define SDLC_CARRY_PULSE_NS  16
`define SDLC_CARRY_CYCLES    ((`SDLC_CARRY_PULSE_NS + `SDLC_CLK_PERIOD_NS - 1) / `SDLC_CLK_PERIOD_NS)

`endif

// ### verification/sdlc_ctrl_model.sv
// Model of the external timing controller driving strobes, start pulse and pixels.
`timescale 1ns/1ps
module sdlc_ctrl_model (
    // Clock and reset
    input wire logic   clk,
    input wire logic   rst_b,
    // Line strobes
    output logic       line_latch_strobe,
    output logic       amp_output_enable_strobe,
    output logic       polarity_sample_strobe,
    // Start pulse pins
    input wire logic   shift_left,
    output logic       start_right,
    output logic       start_left,
    // Pixel words
    output logic       pix_valid,
    input wire logic   pix_ready,
    output logic [17:0] pix_data
);
    logic [2:0] strb;
    logic       start_reg;
    logic       toggle_reg;
    initial begin
        strb = 3'h0;
        start_reg = 1'b0;
        toggle_reg = 1'b0;
        pix_valid = 1'b0;
        pix_data = 18'h00000;
    end
    always @(posedge clk) toggle_reg <= ~toggle_reg;
    assign {polarity_sample_strobe, amp_output_enable_strobe, line_latch_strobe} = strb;
    // The pin we do not drive shows a changing level, so reading it is caught.
    assign start_right = shift_left ? toggle_reg : start_reg;
    assign start_left = shift_left ? start_reg : toggle_reg;
    task automatic pulse(input int k, input int hi);
        strb[k] <= 1'b1;
        repeat (hi) @(posedge clk);
        strb[k] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic start();
        start_reg <= 1'b1;
        @(posedge clk);
        start_reg <= 1'b0;
    endtask
    task automatic push(input logic [17:0] w);
        int n;
        n = 0;
        pix_valid <= 1'b1;
        pix_data <= w;
        @(posedge clk);
        while (pix_ready !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic idle();
        pix_valid <= 1'b0;
        pix_data <= ~pix_data;
    endtask
endmodule // sdlc_ctrl_model

// ### verification/sdlc_line_ctrl_props.sv
// Port assertions for the source driver line control block.
`timescale 1ns/1ps
`include "sdlc_params.svh"
module sdlc_line_ctrl_props (
    // Clock, reset and register writes
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire logic [`SDLC_ADDR_W-1:0] reg_addr,
    input wire logic [15:0]             reg_wdata,
    input wire logic                    reg_wr,
    // Line controls
    input wire logic                    timing_gen_bypass_select,
    input wire logic                    right_start_pulse_oe,
    input wire logic                    left_start_pulse_oe,
    input wire logic                    line_latch_strobe,
    input wire logic                    amp_output_enable_strobe,
    input wire logic                    polarity_select,
    input wire logic                    polarity_sample_strobe,
    // Outputs
    input wire logic                    dac_load,
    input wire logic                    positive_polarity,
    input wire logic                    common_high,
    input wire logic                    amp_enable,
    input wire logic                    output_switch_on,
    input wire logic                    boost_triple_select,
    input wire logic                    external_divider_select,
    input wire logic [2:0]              source_level_select,
    input wire logic [2:0]              gate_ref_level_select
);
    // ==========
    // Drive is only owed once a latch strobe has started normal operation.
    logic seen_reg;
    logic seen_next;
    logic bp;
    assign bp = timing_gen_bypass_select;
    always_comb seen_next = seen_reg | (line_latch_strobe & bp);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) seen_reg <= 1'b0;
        else seen_reg <= seen_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========
    latch_load_a: assert property ($rose(line_latch_strobe) && bp |-> !dac_load ##[1:4] dac_load)
        else $error("latch strobe gave no timely converter load");
    latch_hiz_a: assert property ($rose(line_latch_strobe) && bp |-> ##[1:4] !output_switch_on [*2])
        else $error("outputs not released after latch strobe");
    ap_drive_a: assert property (seen_reg && $fell(amp_output_enable_strobe) && bp
        |-> ##[1:4] (amp_enable && output_switch_on))
        else $error("no drive after amplifier strobe fell");
    pol_pair_a: assert property (positive_polarity != common_high)
        else $error("polarity and common level disagree");
    pol_take_a: assert property ($rose(polarity_sample_strobe) && bp
        |-> ##4 positive_polarity == $past(polarity_select, 4))
        else $error("polarity not captured on sample strobe");
    pol_hold_a: assert property ((!$rose(polarity_sample_strobe)) [*5] |-> $stable(positive_polarity))
        else $error("polarity changed without sample strobe");
    cfg_out_a: assert property (reg_wr && reg_addr == `SDLC_REG_CONFIG |=> {gate_ref_level_select,
        source_level_select, external_divider_select, boost_triple_select} == $past(reg_wdata[7:0]))
        else $error("supply selects do not follow config");
    idle_pins_a: assert property (!bp [*3] |-> !(right_start_pulse_oe || left_start_pulse_oe || output_switch_on))
        else $error("pins driven while bypass low");
    dir_oe_a: assert property (bp [*3] |-> right_start_pulse_oe != left_start_pulse_oe)
        else $error("start pins not one in, one out");
endmodule // sdlc_line_ctrl_props

bind sdlc_line_ctrl sdlc_line_ctrl_props i_props (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .timing_gen_bypass_select, .right_start_pulse_oe, .left_start_pulse_oe, .line_latch_strobe,
    .amp_output_enable_strobe, .polarity_select, .polarity_sample_strobe, .dac_load, .positive_polarity,
    .common_high, .amp_enable, .output_switch_on, .boost_triple_select, .external_divider_select,
    .source_level_select, .gate_ref_level_select);

// ### verification/sdlc_line_ctrl_tb.sv
// Self-checking bench for the source driver line control block.
`timescale 1ns/1ps
`include "sdlc_params.svh"
module sdlc_line_ctrl_tb;
    localparam int PIX = 4;
    // ==========
    logic clk, rst_b, reg_wr, reg_rd, rd_d, timing_gen_bypass_select, polarity_select, shift_left;
    logic [`SDLC_ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic right_start_pulse_in, right_start_pulse_out, right_start_pulse_oe, start_right;
    logic left_start_pulse_in, left_start_pulse_out, left_start_pulse_oe, start_left;
    logic line_latch_strobe, amp_output_enable_strobe, polarity_sample_strobe, pix_valid, pix_ready;
    logic [17:0] pix_data;
    logic [18*PIX-1:0] dac_data, exp_line;
    logic dac_load, positive_polarity, common_high, amp_enable, output_switch_on, bias_setup;
    logic boost_triple_select, external_divider_select;
    logic [2:0] source_level_select, gate_ref_level_select;
    logic [31:0] e;
    logic [31:0] exp_rd[$];
    logic [18*PIX-1:0] exp_dac[$];
    int bad_count, checks_done, seed, cycles;
    assign right_start_pulse_in = right_start_pulse_oe ? right_start_pulse_out : start_right;
    assign left_start_pulse_in = left_start_pulse_oe ? left_start_pulse_out : start_left;
    sdlc_line_ctrl #(.PIXELS(PIX), .DATA_W(18), .FIFO_DEPTH(8)) i_dut (.clk, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .timing_gen_bypass_select, .right_start_pulse_in, .right_start_pulse_out,
        .right_start_pulse_oe, .left_start_pulse_in, .left_start_pulse_out, .left_start_pulse_oe,
        .line_latch_strobe, .amp_output_enable_strobe, .polarity_select, .polarity_sample_strobe, .pix_valid,
        .pix_ready, .pix_data, .dac_data, .dac_load, .positive_polarity, .common_high, .amp_enable,
        .output_switch_on, .bias_setup, .boost_triple_select, .external_divider_select, .source_level_select,
        .gate_ref_level_select);
    sdlc_ctrl_model i_ctrl (.clk, .rst_b, .line_latch_strobe, .amp_output_enable_strobe,
        .polarity_sample_strobe, .shift_left, .start_right, .start_left, .pix_valid, .pix_ready, .pix_data);
    // The clock never stops, so the block can finish work after a latch.
    initial clk = 1'b0;
    always #4 clk = ~clk;
    // ==========
    task automatic chk(input logic ok);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: port value mismatch", $time);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] x);
        exp_rd.push_back({m, x});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic line(input logic left);
        logic [17:0] w;
        int n;
        shift_left <= left;
        wr(`SDLC_REG_CONFIG, {7'h00, left, 8'h00});
        exp_line = '0;
        i_ctrl.start();
        for (int i = 0; i < PIX; i++) begin
            w = 18'($random(seed));
            i_ctrl.push(w);
            exp_line = left ? {w, exp_line[18*PIX-1:18]} : {exp_line[18*PIX-19:0], w};
        end
        i_ctrl.idle();
        n = 0;
        while ((left ? right_start_pulse_out : left_start_pulse_out) !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(n < 40);
        exp_dac.push_back(exp_line);
        i_ctrl.pulse(0, 2);
        i_ctrl.pulse(1, 3);
        chk(amp_enable & output_switch_on & !bias_setup);
        polarity_select <= left;
        i_ctrl.pulse(2, 1);
        chk(positive_polarity === left && common_high === !left);
        polarity_select <= !left;
    endtask
    // ==========
    always @(posedge clk) begin
        rd_d <= reg_rd;
        cycles <= cycles + 1;
        if (rd_d === 1'b1) begin
            e = exp_rd.pop_front();
            chk((reg_rdata & e[31:16]) === e[15:0]);
        end
        if (dac_load === 1'b1 && exp_dac.size() > 0) chk(dac_data === exp_dac.pop_front());
        if (cycles == 5000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            stop_test();
        end
    end
    initial begin
        {seed, bad_count, checks_done, cycles} = {32'd56, 96'd0};
        {rst_b, reg_wr, reg_rd, rd_d, timing_gen_bypass_select, polarity_select, shift_left} = 7'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(`SDLC_REG_STATUS, 16'hFFE1, 16'h0020);
        i_ctrl.pulse(0, 2);
        rd(`SDLC_REG_STATUS, 16'h0041, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            v = 16'($random(seed));
            wr(`SDLC_REG_CONFIG, v);
            rd(`SDLC_REG_CONFIG, 16'hFFFF, v & 16'h01FF);
        end
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'hFFFF, 16'h0000);
        timing_gen_bypass_select <= 1'b1;
        repeat (4) @(posedge clk);
        i_ctrl.pulse(0, 2);
        rd(`SDLC_REG_STATUS, 16'h0041, 16'h0041);
        line(1'b1);
        line(1'b0);
        for (int i = 0; i < 8; i++) i_ctrl.push(18'(i));
        repeat (2) @(posedge clk);
        chk(pix_ready === 1'b0);
        i_ctrl.idle();
        rd(`SDLC_REG_STATUS, 16'h0080, 16'h0080);
        rd(`SDLC_REG_STATUS, 16'h0080, 16'h0000);
        exp_dac.push_back('0);
        i_ctrl.pulse(0, 2);
        chk(pix_ready === 1'b1);
        chk(exp_dac.size() == 0 && exp_rd.size() == 0);
        stop_test();
    end
endmodule // sdlc_line_ctrl_tb
